// ==== rtl/mie_alu.sv ====
/*
  combinational datapath for subtract, exclusive-or and nibble exchange.
  operands are stable during the cycle in which the op is presented.
*/
`timescale 1ns/1ps
module mie_alu import mie_pkg::*; (
  input  wire mie_instr_t   instr,
  input  wire logic [7:0]   acc,
  input  wire logic [7:0]   fdata,
  output wire mie_alu_out_t alu_out
);
  wire logic       is_lit     = (instr.op == MIE_OP_SUBLIT) || (instr.op == MIE_OP_XORLIT);
  wire logic       is_sub     = (instr.op == MIE_OP_SUBLIT) || (instr.op == MIE_OP_SUBFILE);
  wire logic       is_xor     = (instr.op == MIE_OP_XORLIT) || (instr.op == MIE_OP_XORFILE);
  wire logic       is_swap    = (instr.op == MIE_OP_SWAPFILE);
  wire logic       is_fileop  = (instr.op == MIE_OP_SUBFILE) || (instr.op == MIE_OP_XORFILE)
                                || is_swap;
  wire logic [7:0] src        = is_lit ? instr.literal : fdata;
  // two's complement: src + ~acc + 1, carry out means no borrow
  wire logic [8:0] diff       = {1'b0, src} + {1'b0, ~acc} + 9'h001;
  wire logic [4:0] low_diff   = {1'b0, src[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
  wire logic [7:0] xor_res    = acc ^ src;
  wire logic [7:0] swap_res   = {fdata[LO_NIB_MSB:LO_NIB_LSB],
                                 fdata[HI_NIB_MSB:HI_NIB_LSB]};
  wire logic [7:0] res        = is_sub ? diff[7:0] : (is_xor ? xor_res : swap_res);

  assign alu_out.result           = res;
  assign alu_out.carry            = diff[8];
  assign alu_out.digit_carry_flag = low_diff[4];
  assign alu_out.zero_result_flag = (res == 8'h00);
  assign alu_out.upd_carries      = is_sub;
  assign alu_out.upd_z            = is_sub || is_xor;
  assign alu_out.to_file          = is_fileop && (instr.dest == DEST_FILE);
  assign alu_out.to_acc           = is_lit || (is_fileop && (instr.dest == DEST_ACC));
endmodule

// ==== rtl/mie_exec.sv ====
/*
  execution of return, power-down, subtract, exclusive-or and nibble exchange.
  assumes a fetch unit that holds the op until op_ready and a data file that
  answers fdata combinationally for faddr; file writes leave on file_we.
*/
`timescale 1ns/1ps
// Functional notes
// - return pops stack into pc, flags kept
// - return takes two instruction cycles
// - power-down clears watchdog count and prescaler
// - power-down clears power-down, sets timeout flag
// - power-down enters sleep, oscillator halted
// - literal minus accumulator, sets carries and zero
// - literal xor into accumulator, z only
// - file minus accumulator, sets carries and zero
// - destination bit picks accumulator or file
// - xor with file, routed, z only
// - nibble exchange of file, no flags
// - exchange result to accumulator or file
module mie_exec import mie_pkg::*; (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             op_valid,
  input  wire mie_instr_t       instr,
  input  wire logic [7:0]       fdata,
  input  wire logic             call_push,
  input  wire logic [PC_W-1:0]  call_addr,
  input  wire logic             wake,
  input  wire logic             wdg_tick,
  output logic                  op_ready,
  output logic      [7:0]       working_accumulator,
  output logic      [PC_W-1:0]  pc,
  output logic                  pc_load,
  output logic                  file_we,
  output logic      [6:0]       file_waddr,
  output logic      [7:0]       file_wdata,
  output mie_status_t           status,
  output logic      [WDG_W-1:0] watchdog_count,
  output logic      [PRE_W-1:0] wdg_prescaler,
  output logic                  sleeping,
  output logic                  osc_halt
);
  typedef enum logic [1:0] {
    MIE_RUN,
    MIE_RET2,
    MIE_SLEEP
  } mie_state_t;

  mie_state_t      state;
  mie_state_t      next_state;
  mie_alu_out_t    alu_out;
  logic [PC_W-1:0] top_of_stack_entry;

  wire logic take      = op_valid && (state == MIE_RUN);
  wire logic do_ret    = take && (instr.op == MIE_OP_RET);
  wire logic do_sleep  = take && (instr.op == MIE_OP_SLEEP);
  wire logic do_alu    = take && (alu_out.upd_z || instr.op == MIE_OP_SWAPFILE);
  wire logic prescale_wrap = (wdg_prescaler == {PRE_W{1'b1}});

  mie_alu u_alu (
    .instr   (instr),
    .acc     (working_accumulator),
    .fdata   (fdata),
    .alu_out (alu_out)
  );

  mie_stack u_stack (
    .clk                (clk),
    .sys_rst            (sys_rst),
    .push               (call_push && (state == MIE_RUN)),
    .push_addr          (call_addr),
    .pop                (do_ret),
    .top_of_stack_entry (top_of_stack_entry)
  );

  // return holds the core for a second cycle while the fetch is refilled
  always_comb begin
    next_state = state;
    case (state)
      MIE_RUN: begin
        if (do_ret) begin
          next_state = MIE_RET2;
        end else if (do_sleep) begin
          next_state = MIE_SLEEP;
        end
      end
      MIE_RET2: begin
        next_state = MIE_RUN;
      end
      MIE_SLEEP: begin
        if (wake) begin
          next_state = MIE_RUN;
        end
      end
      default: begin
        next_state = MIE_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= MIE_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      op_ready <= 1'b1;
      sleeping <= 1'b0;
      osc_halt <= 1'b0;
    end else begin
      op_ready <= (next_state == MIE_RUN);
      sleeping <= (next_state == MIE_SLEEP);
      osc_halt <= (next_state == MIE_SLEEP);
    end
  end

  // flags stay untouched by return and nibble exchange
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc      <= PC_RST;
      pc_load <= 1'b0;
    end else begin
      pc_load <= do_ret;
      if (do_ret) begin
        pc <= top_of_stack_entry;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      working_accumulator <= ACC_RST;
    end else if (do_alu && alu_out.to_acc) begin
      working_accumulator <= alu_out.result;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      file_we    <= 1'b0;
      file_waddr <= '0;
      file_wdata <= 8'h00;
    end else begin
      file_we <= do_alu && alu_out.to_file;
      if (do_alu && alu_out.to_file) begin
        file_waddr <= instr.faddr;
        file_wdata <= alu_out.result;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status.carry            <= 1'b0;
      status.digit_carry_flag <= 1'b0;
      status.zero_result_flag <= 1'b0;
      status.timeout_flag     <= TIMEOUT_RST;
      status.power_down_flag  <= PWRDN_RST;
    end else begin
      if (do_alu && alu_out.upd_carries) begin
        status.carry            <= alu_out.carry;
        status.digit_carry_flag <= alu_out.digit_carry_flag;
      end
      if (do_alu && alu_out.upd_z) begin
        status.zero_result_flag <= alu_out.zero_result_flag;
      end
      if (do_sleep) begin
        status.power_down_flag <= 1'b0;
        status.timeout_flag    <= 1'b1;
      end
    end
  end

  // watchdog keeps counting in sleep; only reset and the power-down op clear it here
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      watchdog_count <= WDG_CLEAR;
      wdg_prescaler  <= PRE_CLEAR;
    end else if (do_sleep) begin
      watchdog_count <= WDG_CLEAR;
      wdg_prescaler  <= PRE_CLEAR;
    end else if (wdg_tick) begin
      wdg_prescaler <= PRE_W'(wdg_prescaler + 8'h01);
      if (prescale_wrap) begin
        watchdog_count <= WDG_W'(watchdog_count + 8'h01);
      end
    end
  end
endmodule

// ==== rtl/mie_pkg.sv ====
/*
  shared constants and types for the instruction-subset execution block.
  assumes a single 10 MHz clock and an external fetch unit that presents one decoded op.
*/
package mie_pkg;
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned FADDR_W      = 7;
  localparam int unsigned PC_W         = 13;
  localparam int unsigned STACK_DEPTH  = 8;
  localparam int unsigned SP_W         = 3;
  localparam int unsigned WDG_W        = 8;
  localparam int unsigned PRE_W        = 8;
  localparam logic [7:0]  WDG_CLEAR    = 8'h00;
  localparam logic [7:0]  PRE_CLEAR    = 8'h00;
  localparam logic [7:0]  ACC_RST      = 8'h00;
  localparam logic [12:0] PC_RST       = 13'h0000;
  localparam logic        DEST_ACC     = 1'b0;
  localparam logic        DEST_FILE    = 1'b1;
  localparam int unsigned RET_CYCLES   = 2;
  localparam int unsigned HI_NIB_MSB   = 7;
  localparam int unsigned HI_NIB_LSB   = 4;
  localparam int unsigned LO_NIB_MSB   = 3;
  localparam int unsigned LO_NIB_LSB   = 0;
  localparam logic        TIMEOUT_RST  = 1'b1;
  localparam logic        PWRDN_RST    = 1'b1;

  typedef enum logic [2:0] {
    MIE_OP_NONE,
    MIE_OP_RET,
    MIE_OP_SLEEP,
    MIE_OP_SUBLIT,
    MIE_OP_XORLIT,
    MIE_OP_SUBFILE,
    MIE_OP_XORFILE,
    MIE_OP_SWAPFILE
  } mie_op_t;

  typedef struct packed {
    mie_op_t           op;
    logic [7:0]        literal;
    logic [6:0]        faddr;
    logic              dest;
  } mie_instr_t;

  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero_result_flag;
    logic timeout_flag;
    logic power_down_flag;
  } mie_status_t;

  typedef struct packed {
    logic [7:0] result;
    logic       carry;
    logic       digit_carry_flag;
    logic       zero_result_flag;
    logic       upd_carries;
    logic       upd_z;
    logic       to_file;
    logic       to_acc;
  } mie_alu_out_t;
endpackage

// ==== rtl/mie_stack.sv ====
/*
  eight-entry circular return-address stack.
  push and pop never arrive together; overflow wraps silently as the core does.
*/
`timescale 1ns/1ps
module mie_stack import mie_pkg::*; (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             push,
  input  wire logic [PC_W-1:0]  push_addr,
  input  wire logic             pop,
  output logic      [PC_W-1:0]  top_of_stack_entry
);
  logic [PC_W-1:0] entries [STACK_DEPTH];
  logic [SP_W-1:0] sp;

  assign top_of_stack_entry = entries[SP_W'(sp - 3'h1)];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sp <= '0;
    end else if (push) begin
      sp <= SP_W'(sp + 3'h1);
    end else if (pop) begin
      sp <= SP_W'(sp - 3'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      entries[sp] <= push_addr;
    end
  end
endmodule

// ==== tb/mie_exec_props.sv ====
/*
  port-level assertions for the instruction-subset execution block.
  assumes one clock and a synchronous active-high reset, bound from the bench.
*/
`timescale 1ns/1ps
module mie_exec_props import mie_pkg::*; (
  input wire logic             clk,
  input wire logic             sys_rst,
  input wire logic             op_valid,
  input wire mie_instr_t       instr,
  input wire logic [7:0]       fdata,
  input wire logic             op_ready,
  input wire logic [7:0]       working_accumulator,
  input wire logic             pc_load,
  input wire logic             file_we,
  input wire logic [6:0]       file_waddr,
  input wire logic [7:0]       file_wdata,
  input wire mie_status_t      status,
  input wire logic [WDG_W-1:0] watchdog_count,
  input wire logic [PRE_W-1:0] wdg_prescaler,
  input wire logic             sleeping,
  input wire logic             osc_halt
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // operands of the op taken at the last edge; results are judged against them
  logic        tk;
  mie_instr_t  qi;
  logic [7:0]  qa;
  logic [7:0]  qf;
  mie_status_t qs;
  always_ff @(posedge clk) begin
    tk <= op_valid && op_ready && !sys_rst;
    qi <= instr;
    qa <= working_accumulator;
    qf <= fdata;
    qs <= status;
  end
  sequence s_ret_gap;
    pc_load && !op_ready;
  endsequence
  property p_ret;
    op_valid && op_ready && instr.op == MIE_OP_RET |=> s_ret_gap ##1 op_ready;
  endproperty
  a_ret: assert property (p_ret) else $error("return timing wrong");
  property p_ret_keep;
    tk && qi.op == MIE_OP_RET |-> status == qs && working_accumulator == qa;
  endproperty
  a_ret_keep: assert property (p_ret_keep) else $error("return changed state");
  property p_slp_cnt;
    tk && qi.op == MIE_OP_SLEEP |-> watchdog_count == 8'h00 && wdg_prescaler == 8'h00;
  endproperty
  a_slp_cnt: assert property (p_slp_cnt) else $error("sleep counters kept");
  property p_slp_flags;
    tk && qi.op == MIE_OP_SLEEP |->
      status == {qs.carry, qs.digit_carry_flag, qs.zero_result_flag, 1'b1, 1'b0};
  endproperty
  a_slp_flags: assert property (p_slp_flags) else $error("sleep flags wrong");
  property p_slp_halt;
    tk && qi.op == MIE_OP_SLEEP |-> sleeping && osc_halt && !op_ready;
  endproperty
  a_slp_halt: assert property (p_slp_halt) else $error("sleep not entered");
  property p_sublit;
    tk && qi.op == MIE_OP_SUBLIT |-> working_accumulator == 8'(qi.literal - qa)
      && status.carry == (qi.literal >= qa)
      && status.digit_carry_flag == (qi.literal[3:0] >= qa[3:0])
      && status.zero_result_flag == (qi.literal == qa);
  endproperty
  a_sublit: assert property (p_sublit) else $error("literal subtract wrong");
  property p_subf;
    tk && qi.op == MIE_OP_SUBFILE && qi.dest |-> file_we && file_waddr == qi.faddr
      && file_wdata == 8'(qf - qa) && working_accumulator == qa && status.carry == (qf >= qa);
  endproperty
  a_subf: assert property (p_subf) else $error("file subtract wrong");
  property p_xorl;
    tk && qi.op == MIE_OP_XORLIT |-> working_accumulator == (qa ^ qi.literal)
      && status.zero_result_flag == ((qa ^ qi.literal) == 8'h00) && status.carry == qs.carry;
  endproperty
  a_xorl: assert property (p_xorl) else $error("literal xor wrong");
  property p_xorf;
    tk && qi.op == MIE_OP_XORFILE |-> (qi.dest ? file_wdata : working_accumulator) == (qa ^ qf)
      && status.digit_carry_flag == qs.digit_carry_flag;
  endproperty
  a_xorf: assert property (p_xorf) else $error("file xor wrong");
  property p_swap;
    tk && qi.op == MIE_OP_SWAPFILE |->
      (qi.dest ? file_wdata : working_accumulator) == {qf[3:0], qf[7:4]} && status == qs;
  endproperty
  a_swap: assert property (p_swap) else $error("nibble exchange wrong");
endmodule

// ==== tb/mie_exec_tb_top.sv ====
/*
  self-checking bench for the execution block: ops are issued as call sequences.
  assumes the bench stands in for the fetch unit and the data file.
*/
`timescale 1ns/1ps
module mie_exec_tb_top import mie_pkg::*; ;
  logic        clk = 0, sys_rst = 1, op_valid = 0, call_push = 0, wake = 0, wdg_tick = 0;
  mie_instr_t  instr = '0;
  logic [7:0]  fdata = 8'h00, acc_m = 8'h00;
  logic [12:0] call_addr = 13'h0000, pc;
  logic        op_ready, pc_load, file_we, sleeping, osc_halt;
  logic [7:0]  working_accumulator, file_wdata, watchdog_count, wdg_prescaler;
  logic [6:0]  file_waddr;
  mie_status_t status;
  int          bad_count = 0, n_tests = 0;
  logic [15:0] tab [4] = '{16'h0505, 16'h0605, 16'h0f20, 16'h00ff};
  always #50 clk = ~clk;
  mie_exec dut_u (.clk, .sys_rst, .op_valid, .instr, .fdata, .call_push, .call_addr, .wake,
    .wdg_tick, .op_ready, .working_accumulator, .pc, .pc_load, .file_we, .file_waddr,
    .file_wdata, .status, .watchdog_count, .wdg_prescaler, .sleeping, .osc_halt);
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // op_valid stays high so consecutive calls issue back to back
  task automatic op_do(input mie_op_t op, input logic [7:0] k, input logic [6:0] fa,
                       input logic d, input logic [7:0] fd);
    instr = '{op, k, fa, d};
    fdata = fd;
    op_valid = 1'b1;
    @(negedge clk);
  endtask
  task automatic idle;
    op_valid = 1'b0;
    @(negedge clk);
  endtask
  task automatic set_acc(input logic [7:0] v);
    op_do(MIE_OP_XORLIT, acc_m ^ v, 7'h00, 1'b0, 8'h00);
    acc_m = v;
    chk("acc", working_accumulator, v);
    chk("zero", status.zero_result_flag, v == 8'h00);
  endtask
  task automatic sub_case(input logic [7:0] a, input logic [7:0] k);
    set_acc(a);
    op_do(MIE_OP_SUBLIT, k, 7'h00, 1'b0, 8'h00);
    acc_m = k - a;
    chk("acc", working_accumulator, acc_m);
    chk("flags", status, {k >= a, k[3:0] >= a[3:0], acc_m == 8'h00, 2'h3});
  endtask
  initial begin
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    chk("ready", op_ready, 1'b1);
    chk("flags", status, 5'h03);
    call_addr = 13'h0abc;
    call_push = 1'b1;
    @(negedge clk);
    call_addr = 13'h1234;
    @(negedge clk);
    call_push = 1'b0;
    foreach (tab[i]) sub_case(tab[i][15:8], tab[i][7:0]);
    set_acc(8'h10);
    op_do(MIE_OP_SUBFILE, 8'h00, 7'h7f, 1'b1, 8'h08);
    chk("we", file_we, 1'b1);
    chk("waddr", file_waddr, 7'h7f);
    chk("wdata", file_wdata, 8'hf8);
    chk("acc", working_accumulator, 8'h10);
    chk("flags", status, 5'h0b);
    op_do(MIE_OP_SUBFILE, 8'h00, 7'h05, 1'b0, 8'h10);
    chk("we", file_we, 1'b0);
    chk("acc", working_accumulator, 8'h00);
    chk("flags", status, 5'h1f);
    op_do(MIE_OP_XORFILE, 8'h00, 7'h03, 1'b1, 8'h5a);
    chk("wdata", file_wdata, 8'h5a);
    chk("flags", status, 5'h1b);
    op_do(MIE_OP_XORFILE, 8'h00, 7'h03, 1'b0, 8'h3c);
    chk("acc", working_accumulator, 8'h3c);
    chk("we", file_we, 1'b0);
    op_do(MIE_OP_SWAPFILE, 8'h00, 7'h12, 1'b0, 8'ha5);
    chk("acc", working_accumulator, 8'h5a);
    chk("flags", status, 5'h1b);
    op_do(MIE_OP_SWAPFILE, 8'h00, 7'h12, 1'b1, 8'h3c);
    chk("wdata", file_wdata, 8'hc3);
    chk("waddr", file_waddr, 7'h12);
    op_do(MIE_OP_RET, 8'h00, 7'h00, 1'b0, 8'h00);
    chk("pc", pc, 13'h1234);
    chk("load", pc_load, 1'b1);
    chk("ready", op_ready, 1'b0);
    idle();
    chk("ready", op_ready, 1'b1);
    op_do(MIE_OP_RET, 8'h00, 7'h00, 1'b0, 8'h00);
    chk("pc", pc, 13'h0abc);
    idle();
    // enough ticks to wrap the prescaler once, so both clears below are visible
    wdg_tick = 1'b1;
    repeat (257) @(negedge clk);
    wdg_tick = 1'b0;
    chk("watchdog", {watchdog_count, wdg_prescaler}, 16'h0101);
    op_do(MIE_OP_SLEEP, 8'h00, 7'h00, 1'b0, 8'h00);
    chk("watchdog", {watchdog_count, wdg_prescaler}, 16'h0000);
    chk("flags", status, 5'h1a);
    chk("halt", {sleeping, osc_halt, op_ready}, 3'h6);
    // an op offered in sleep must be ignored
    op_do(MIE_OP_XORLIT, 8'hff, 7'h00, 1'b0, 8'h00);
    chk("acc", working_accumulator, 8'h5a);
    op_valid = 1'b0;
    wake = 1'b1;
    @(negedge clk);
    wake = 1'b0;
    chk("awake", {sleeping, op_ready}, 2'h1);
    give_verdict();
  end
  // about 290 cycles are planned; the margin covers a stuck handshake only
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
endmodule
bind mie_exec mie_exec_props chk_u (.clk, .sys_rst, .op_valid, .instr, .fdata, .op_ready,
  .working_accumulator, .pc_load, .file_we, .file_waddr, .file_wdata, .status,
  .watchdog_count, .wdg_prescaler, .sleeping, .osc_halt);
